// *** sadc_ctrl.sv ***
// Converter control: input select, gain, SAR clock divider, start and track sequencing
//
// Contract
// - Converter powered only while power enable set
// - Selector routes one pin of ports 0-3
// - Only the selected pin becomes analog input
// - Three-bit gain field, 10x=16, 11x=0.5
// - Gain is 1 after reset
// - SAR clock divides system clock by 1, 2, 4, 8 or 16
// - On-demand mode starts on busy-bit write 1
// - Timer mode starts on each Timer 2 overflow while not busy
// - Busy bit high for whole conversion
// - Busy falling at conversion end sets done, raises interrupt; a power-off abort does not
// - Result register holds each completed conversion
// - Default mode tracks except while converting
// - Low-power demand: track 3 SAR clocks, convert
// - Low-power timer: track 3 SAR clocks, convert
// - Tracking off during chip standby
`timescale 1ns/10ps
module sadc_ctrl
   import sadc_pkg::*;
#(
   parameter int TRK_CLKS = TRACK_CLKS
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Register port
   input wire sadc_sfr_t sfr_i,
   output logic [7:0] sfr_rdata_o,
   // Chip events
   input wire logic t2_ovf_i,
   input wire logic standby_i,
   input wire logic irq_en_i,
   output logic irq_o,
   // SAR core
   input wire logic sar_eoc_i,
   input wire logic [7:0] sar_data_i,
   output sadc_ana_t ana_o,
   // Analog-mode pin enables, port*8+pin
   output logic [31:0] ain_en_o
);

   if (TRK_CLKS < 1 || TRK_CLKS > 15) begin : g_chk
      $error("TRK_CLKS must be 1 to 15");
   end

   // Register state
   logic [7:0] amx_r, amx_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   logic [7:0] ctl_r, ctl_nxt;
   logic [7:0] res_r, res_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   // Divider state
   logic [3:0] div_r, div_nxt;
   logic [3:0] div_lim;
   logic tick;
   // Sequencer state
   sadc_state_t st_r, st_nxt;
   logic [3:0] trk_r, trk_nxt;
   logic en, busy, start, finish;
   logic wr_ctl;
   logic [2:0] gain_c;
   logic [4:0] pin_idx;

   assign en = ctl_r[CTL_EN_BIT];
   assign busy = (st_r != ST_IDLE);
   assign wr_ctl = sfr_i.wr && (sfr_i.addr == ADDR_CTL);
   assign finish = en && (st_r == ST_CONV) && sar_eoc_i;

   // Start request; reserved modes never start, and a start while busy is dropped
   always_comb begin
      start = 1'b0;
      if (!busy) begin
         if (ctl_r[STM_LSB+:2] == STM_DEMAND) begin
            start = wr_ctl && sfr_i.wdata[CTL_BUSY_BIT]
                    && sfr_i.wdata[CTL_EN_BIT];
         end else if (ctl_r[STM_LSB+:2] == STM_TIMER) begin
            start = en && t2_ovf_i;
         end
      end
   end

   // Register writes, result capture and read mux
   always_comb begin
      amx_nxt = amx_r;
      cfg_nxt = cfg_r;
      ctl_nxt = ctl_r;
      res_nxt = res_r;
      if (sfr_i.wr && sfr_i.addr == ADDR_AMX) begin
         amx_nxt = {2'h0, sfr_i.wdata[5:0]};
      end
      if (sfr_i.wr && sfr_i.addr == ADDR_CFG) begin
         cfg_nxt = {sfr_i.wdata[7:5], 2'h0, sfr_i.wdata[2:0]};
      end
      if (wr_ctl) begin
         ctl_nxt = sfr_i.wdata;
      end
      // Busy is never stored; it reads from the sequencer
      ctl_nxt[CTL_BUSY_BIT] = 1'b0;
      // Hardware set beats a software clear in the same cycle
      if (finish) begin
         ctl_nxt[CTL_DONE_BIT] = 1'b1;
         res_nxt = sar_data_i;
      end
      case (sfr_i.addr)
         ADDR_AMX: rdata_nxt = amx_r;
         ADDR_CFG: rdata_nxt = cfg_r;
         ADDR_CTL: rdata_nxt = ctl_r | ({7'h0, busy} << CTL_BUSY_BIT);
         ADDR_RES: rdata_nxt = res_r;
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         amx_r <= RST_AMX;
         cfg_r <= RST_CFG;
         ctl_r <= RST_CTL;
         res_r <= RST_RES;
         rdata_r <= 8'h00;
      end else begin
         amx_r <= amx_nxt;
         cfg_r <= cfg_nxt;
         ctl_r <= ctl_nxt;
         res_r <= res_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Divide limit from the divider code, saturating at divide by 16
   always_comb begin
      case (cfg_r[DIV_LSB+:3])
         3'h0: div_lim = 4'h0;
         3'h1: div_lim = 4'h1;
         3'h2: div_lim = 4'h3;
         3'h3: div_lim = 4'h7;
         default: div_lim = 4'hF;
      endcase
   end

   // SAR clock enable; the count rests at zero while powered down
   assign tick = en && (div_r >= div_lim);
   always_comb begin
      div_nxt = 4'h0;
      if (en && !tick) begin
         div_nxt = div_r + 4'h1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         div_r <= 4'h0;
      end else begin
         div_r <= div_nxt;
      end
   end

   // Track and convert sequencer
   always_comb begin
      st_nxt = st_r;
      trk_nxt = trk_r;
      case (st_r)
         ST_IDLE: begin
            trk_nxt = 4'h0;
            if (start) begin
               // Default mode is already tracking, so it converts at once
               st_nxt = ctl_nxt[CTL_TM_BIT] ? ST_TRACK : ST_CONV;
            end
         end
         ST_TRACK: begin
            if (tick) begin
               trk_nxt = trk_r + 4'h1;
               if (trk_r == 4'(TRK_CLKS - 1)) begin
                  st_nxt = ST_CONV;
               end
            end
         end
         ST_CONV: begin
            if (sar_eoc_i) begin
               st_nxt = ST_IDLE;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      // Losing power aborts without reporting completion
      if (!ctl_nxt[CTL_EN_BIT]) begin
         st_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= ST_IDLE;
         trk_r <= 4'h0;
      end else begin
         st_r <= st_nxt;
         trk_r <= trk_nxt;
      end
   end

   // Gain decode to log2(gain)+1
   always_comb begin
      case (cfg_r[GAIN_LSB+:3])
         3'h0: gain_c = 3'h1;
         3'h1: gain_c = 3'h2;
         3'h2: gain_c = 3'h3;
         3'h3: gain_c = 3'h4;
         3'h4, 3'h5: gain_c = GAIN_16;
         default: gain_c = GAIN_HALF;
      endcase
   end

   // Analog controls; tracking follows the mode, and standby forces tracking off in both modes
   always_comb begin
      ana_o.pwr = en;
      ana_o.conv = (st_r == ST_CONV);
      ana_o.tick = tick;
      ana_o.gain = gain_c;
      if (ctl_r[CTL_TM_BIT]) begin
         ana_o.track = en && !standby_i && (st_r == ST_TRACK);
      end else begin
         ana_o.track = en && !standby_i && (st_r != ST_CONV);
      end
   end

   // One analog pin at a time; the rest of the port stays digital
   assign pin_idx = {amx_r[PRT_LSB+:2], amx_r[PIN_LSB+:3]};
   for (genvar i = 0; i < 32; i++) begin : g_pin
      assign ain_en_o[i] = en && amx_r[AMX_EN_BIT] && (pin_idx == 5'(i));
   end

   assign sfr_rdata_o = rdata_r;
   assign irq_o = ctl_r[CTL_DONE_BIT] && irq_en_i;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   property p_pwr_off;
      !en |-> !ana_o.pwr && !ana_o.track && !ana_o.conv && ain_en_o == 32'h0;
   endproperty
   a_pwr_off: assert property (p_pwr_off) else $error("analog active while off");

   property p_pin_sel;
      en && amx_r[AMX_EN_BIT] |-> ain_en_o == (32'h1 << pin_idx);
   endproperty
   a_pin_sel: assert property (p_pin_sel) else $error("wrong analog pin set");

   property p_gain;
      cfg_r[2:1] == 2'h2 |-> ana_o.gain == 3'h5;
   endproperty
   a_gain: assert property (p_gain) else $error("gain code 10x not 16");

   property p_div2;
      en && cfg_r[7:5] == 3'h1 && tick ##1 en && cfg_r[7:5] == 3'h1
         |-> !tick ##1 (tick || !en || cfg_r[7:5] != 3'h1);
   endproperty
   a_div2: assert property (p_div2) else $error("divide by 2 wrong");

   property p_div16;
      en && cfg_r[7] && tick |=> (!tick || !en || !cfg_r[7])[*8];
   endproperty
   a_div16: assert property (p_div16) else $error("divide by 16 too fast");

   property p_demand;
      !busy && ctl_r[3:2] == 2'h0 && wr_ctl && sfr_i.wdata[7:6] == 2'h2
         && sfr_i.wdata[4] |=> st_r == ST_CONV;
   endproperty
   a_demand: assert property (p_demand) else $error("demand start missed");

   property p_timer;
      !busy && en && ctl_r[3:2] == 2'h3 && t2_ovf_i && !wr_ctl |=> busy;
   endproperty
   a_timer: assert property (p_timer) else $error("timer start missed");

   property p_done;
      finish |=> ctl_r[CTL_DONE_BIT] && !busy && res_r == $past(sar_data_i);
   endproperty
   a_done: assert property (p_done) else $error("completion not recorded");

   property p_hold;
      ctl_r[CTL_DONE_BIT] && !wr_ctl |=> ctl_r[CTL_DONE_BIT];
   endproperty
   a_hold: assert property (p_hold) else $error("done flag lost");

   property p_track;
      $rose(st_r == ST_TRACK) |-> (st_r == ST_TRACK || !en)[*1] ##0 trk_r == 4'h0;
   endproperty
   a_track: assert property (p_track) else $error("track count not cleared");

   property p_track_end;
      st_r == ST_TRACK && tick && trk_r == 4'(TRK_CLKS - 1) && ctl_nxt[7] |=> st_r == ST_CONV;
   endproperty
   a_track_end: assert property (p_track_end) else $error("track too long");

   property p_track_dflt;
      en && !ctl_r[CTL_TM_BIT] && !standby_i && st_r != ST_CONV |-> ana_o.track;
   endproperty
   a_track_dflt: assert property (p_track_dflt) else $error("not tracking");

endmodule

// *** sadc_pkg.sv ***
// Package: register map, field layout, modes and carriers of the converter control
package sadc_pkg;
   // Register addresses on the special function register port
   localparam logic [7:0] ADDR_AMX = 8'hBB;
   localparam logic [7:0] ADDR_CFG = 8'hBC;
   localparam logic [7:0] ADDR_CTL = 8'hE8;
   localparam logic [7:0] ADDR_RES = 8'hBE;
   // Reset values
   localparam logic [7:0] RST_AMX = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h60;
   localparam logic [7:0] RST_CTL = 8'h00;
   localparam logic [7:0] RST_RES = 8'h00;
   // Input select fields
   localparam int AMX_EN_BIT = 5;
   localparam int PRT_LSB = 3;
   localparam int PIN_LSB = 0;
   // Configuration fields
   localparam int DIV_LSB = 5;
   localparam int GAIN_LSB = 0;
   // Control fields
   localparam int CTL_EN_BIT = 7;
   localparam int CTL_TM_BIT = 6;
   localparam int CTL_DONE_BIT = 5;
   localparam int CTL_BUSY_BIT = 4;
   localparam int STM_LSB = 2;
   // Start-of-conversion modes
   localparam logic [1:0] STM_DEMAND = 2'h0;
   localparam logic [1:0] STM_TIMER = 2'h3;
   // Low-power tracking length in SAR clocks
   localparam int TRACK_CLKS = 3;
   // Gain codes to the amplifier, as log2(gain)+1
   localparam logic [2:0] GAIN_HALF = 3'h0;
   localparam logic [2:0] GAIN_16 = 3'h5;
   typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} sadc_state_t;
   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
   } sadc_sfr_t;
   // Controls to the analog front end and SAR core
   typedef struct packed {
      logic pwr;
      logic track;
      logic conv;
      logic tick;
      logic [2:0] gain;
   } sadc_ana_t;
endpackage

// *** sadc_sar_model.sv ***
// SAR core stand-in: answers each conversion after a fixed count of SAR clocks
`timescale 1ns/10ps
module sadc_sar_model
   import sadc_pkg::*;
#(
   parameter int N_TICKS = 6
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Controls from the converter control
   input wire sadc_ana_t ana_i,
   // Result back to the control
   output logic eoc_o,
   output logic [7:0] data_o
);
   int cnt_r;
   logic [7:0] res_r;

   // Result steps by 8'h25 per conversion; data toggles when not valid so stale values never match
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 0;
         res_r <= 8'h00;
         eoc_o <= 1'b0;
         data_o <= 8'h00;
      end else begin
         eoc_o <= 1'b0;
         data_o <= ~data_o;
         if (!ana_i.conv) begin
            cnt_r <= 0;
         end else if (ana_i.tick && cnt_r < N_TICKS) begin
            cnt_r <= cnt_r + 1;
            if (cnt_r == N_TICKS - 1) begin
               eoc_o <= 1'b1;
               res_r <= res_r + 8'h25;
               data_o <= res_r + 8'h25;
            end
         end
      end
   end
endmodule

// *** test_sar_adc_mux_and_conversion_control.sv ***
// Self-checking testbench of the converter control
`timescale 1ns/10ps
module test_sar_adc_mux_and_conversion_control;
   import sadc_pkg::*;
   // Gain output expected for codes 7 down to 0
   localparam logic [23:0] GTAB = {3'h0, 3'h0, 3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   sadc_sfr_t sfr = '0;
   logic t2 = 1'b0;
   logic stby = 1'b0;
   logic irqen = 1'b1;
   logic [7:0] rdata;
   logic [7:0] sdata;
   logic [7:0] d;
   logic [7:0] exp_res = 8'h00;
   logic irq;
   logic eoc;
   logic [31:0] ain;
   sadc_ana_t ana;
   int miscompares = 0;
   int n_compared = 0;

   // 40 MHz system clock
   initial forever #12.5 clk_sys_i = ~clk_sys_i;

   sadc_ctrl u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
      .t2_ovf_i(t2), .standby_i(stby), .irq_en_i(irqen), .irq_o(irq), .sar_eoc_i(eoc),
      .sar_data_i(sdata), .ana_o(ana), .ain_en_o(ain));
   sadc_sar_model u_sar (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ana_i(ana), .eoc_o(eoc),
      .data_o(sdata));

   task report_and_stop;
      if (miscompares == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // Register write: strobe lasts exactly one edge
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys_i);
      sfr <= '{a, 1'b1, v};
      @(posedge clk_sys_i);
      sfr.wr <= 1'b0;
      #1;
   endtask

   // Register read: data is registered, so it lands one edge after the address
   task rd(input logic [7:0] a);
      @(posedge clk_sys_i);
      sfr.addr <= a;
      @(posedge clk_sys_i);
      #1;
      d = rdata;
   endtask

   task ticks(output int n);
      n = 0;
      repeat (32) begin
         @(posedge clk_sys_i);
         #1;
         if (ana.tick === 1'b1) n++;
      end
   endtask

   task t_reset;
      chk("gain", 1, ana.gain);
      chk("ain", 0, ain);
      rd(ADDR_AMX);
      chk("sel", RST_AMX, d);
      rd(ADDR_CFG);
      chk("cfg", RST_CFG, d);
      rd(ADDR_CTL);
      chk("ctl", RST_CTL, d);
      rd(8'h00);
      chk("unmapped", 0, d);
   endtask

   task t_gain;
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CFG, {5'h01, i[2:0]});
         chk("gain", GTAB[3*i +: 3], ana.gain);
      end
   endtask

   task t_mux;
      // Pin enables are gated by converter power
      wr(ADDR_CTL, 8'h80);
      for (int p = 0; p < 4; p++) begin
         wr(ADDR_AMX, {3'h1, p[1:0], p[2:0] + 3'h4});
         chk("ain", 32'h1 << (p * 9 + 4), ain);
      end
      wr(ADDR_AMX, 8'h1C);
      chk("ain off", 0, ain);
   endtask

   task t_div;
      int n;
      wr(ADDR_CTL, 8'h00);
      ticks(n);
      chk("tick off", 0, n);
      chk("pwr off", 0, ana.pwr);
      for (int c = 0; c < 6; c++) begin
         wr(ADDR_CFG, {c[2:0], 5'h00});
         wr(ADDR_CTL, 8'h80);
         chk("pwr", 1, ana.pwr);
         repeat (20) @(posedge clk_sys_i);
         ticks(n);
         chk("ticks", 32 >> (c > 4 ? 4 : c), n);
         wr(ADDR_CTL, 8'h00);
      end
   endtask

   // Idle tracking, standby shutdown, and a start refused in a reserved mode
   task t_stby;
      wr(ADDR_CTL, 8'h80);
      chk("idle track", 1, ana.track);
      @(posedge clk_sys_i);
      stby <= 1'b1;
      @(posedge clk_sys_i);
      #1;
      chk("standby", 0, ana.track);
      @(posedge clk_sys_i);
      stby <= 1'b0;
      wr(ADDR_CTL, 8'h84);
      wr(ADDR_CTL, 8'h94);
      chk("no start", 0, ana.conv);
      wr(ADDR_CTL, 8'h80);
   endtask

   // One conversion, started by a busy write or a timer overflow
   task t_conv(input logic [7:0] ctl, input logic tmr);
      int n;
      // Slowest SAR clock; a 40 MHz system clock cannot get below 2.5 MHz
      wr(ADDR_CFG, 8'h80);
      wr(ADDR_CTL, ctl);
      if (tmr) begin
         @(posedge clk_sys_i);
         t2 <= 1'b1;
         @(posedge clk_sys_i);
         t2 <= 1'b0;
         #1;
      end
      n = 0;
      if (ctl[6]) begin
         chk("lp track", 1, ana.track);
         for (int i = 0; i < 100 && ana.conv !== 1'b1; i++) begin
            if (ana.tick === 1'b1) n++;
            @(posedge clk_sys_i);
            #1;
         end
         chk("lp ticks", TRACK_CLKS, n);
      end
      chk("conv", 1, ana.conv);
      chk("track in conv", 0, ana.track);
      rd(ADDR_CTL);
      chk("busy", 1, d[CTL_BUSY_BIT]);
      n = 0;
      d = 8'h00;
      while (d[CTL_DONE_BIT] !== 1'b1 && n < 100) begin
         rd(ADDR_CTL);
         n++;
      end
      chk("done", 1, d[CTL_DONE_BIT]);
      if (d[CTL_DONE_BIT] !== 1'b1) report_and_stop;
      chk("busy low", 0, d[CTL_BUSY_BIT]);
      exp_res = exp_res + 8'h25;
      rd(ADDR_RES);
      chk("result", exp_res, d);
      chk("irq", 1, irq);
      @(posedge clk_sys_i);
      irqen <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      chk("irq masked", 0, irq);
      repeat (10) @(posedge clk_sys_i);
      irqen <= 1'b1;
      rd(ADDR_CTL);
      chk("done held", 1, d[CTL_DONE_BIT]);
      wr(ADDR_CTL, 8'h80);
      chk("irq clear", 0, irq);
   endtask

   initial begin
      repeat (20) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_reset;
      t_gain;
      t_mux;
      t_div;
      t_stby;
      t_conv(8'h90, 1'b0);
      t_conv(8'hD0, 1'b0);
      t_conv(8'h8C, 1'b1);
      t_conv(8'hCC, 1'b1);
      report_and_stop;
   end
endmodule
